// >>> pump_status_pkg.sv
// Constants and types shared by the pump status indication logic.
package pump_status_pkg;
  localparam int unsigned CLOCK_MHZ = 200;
  // Shortest visible activity blink, and the half period of slow blinking.
  localparam int unsigned LAMP_STRETCH_MS = 50;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned START_TIMEOUT_MS = 10000;
  localparam int unsigned LAMP_STRETCH_CYC = LAMP_STRETCH_MS * CLOCK_MHZ * 1000;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLOCK_MHZ * 1000;
  localparam longint unsigned START_TIMEOUT_CYC =
    64'(START_TIMEOUT_MS) * CLOCK_MHZ * 1000;

  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] INVERT_ADDR = 8'h04;
  localparam logic [7:0] SOFT_AUTO_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;
  localparam logic [7:0] INT_STATUS_ADDR = 8'h10;
  localparam logic [7:0] INT_MASK_ADDR = 8'h14;
  localparam logic [7:0] DISPLAY_ADDR = 8'h18;
  localparam logic [7:0] DISPLAY_LAST_ADDR = 8'h24;

  // Control register fields.
  localparam int CTRL_FLOAT_EN = 0;
  localparam int CTRL_HARD_MON = 1;
  localparam int CTRL_PUMP_UP = 2;
  localparam int CTRL_SILENCE = 3;
  localparam int CTRL_FAIL_CLR = 4;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [15:0] INVERT_RESET = 16'h0000;
  localparam logic [2:0] SOFT_AUTO_RESET = 3'h7;
  localparam logic [2:0] INT_MASK_RESET = 3'h0;

  // Interrupt event bits.
  localparam int EV_PHASE = 0;
  localparam int EV_FLOAT = 1;
  localparam int EV_FAIL = 2;

  // Discrete input positions.
  localparam int DI_HIGH_FLOAT = 9;
  localparam int DI_LOW_FLOAT = 10;
  localparam int DI_SILENCE = 11;
  localparam int DI_INHIBIT = 12;
  localparam int DI_POWER_QUALITY = 13;

  // Display characters.
  localparam logic [7:0] CHAR_OFF = 8'h2d;
  localparam logic [7:0] CHAR_DIGIT1 = 8'h31;
  localparam logic [7:0] CHAR_LETTER_A = 8'h41;
  localparam int DIGIT_INPUTS = 9;

  typedef enum logic [1:0] {FAIL_NONE, FAIL_START, FAIL_OVERTEMP,
                            FAIL_SEAL} fail_code_t;
  typedef enum logic [1:0] {SCREEN_HOME, SCREEN_PHASE,
                            SCREEN_FLOAT} screen_t;

  function automatic logic [7:0] di_char(int unsigned idx, logic on);
    logic [7:0] c;
    c = CHAR_OFF;
    if (on && idx < DIGIT_INPUTS) begin
      c = CHAR_DIGIT1 + 8'(idx);
    end else if (on) begin
      c = CHAR_LETTER_A + 8'(idx - DIGIT_INPUTS);
    end
    return c;
  endfunction
endpackage

// >>> pump_status.sv
// Lamp, input display and pump permissive logic with an APB register file.
//
// Chosen here: the address map and the APB slave port.

module pump_status #(
  parameter int unsigned LAMP_STRETCH = pump_status_pkg::LAMP_STRETCH_CYC,
  parameter int unsigned BLINK_HALF = pump_status_pkg::BLINK_HALF_CYC,
  parameter longint unsigned START_TIMEOUT =
    pump_status_pkg::START_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] di_raw,
  input wire logic rx_line,
  input wire logic panel_present,
  input wire logic [2:0] seal_fail,
  input wire logic tx_active,
  input wire logic config_corrupt,
  input wire logic [2:0] stage_call,
  output logic [2:0] pump_run,
  output logic [2:0] not_in_auto_tag,
  output logic rx_lamp,
  output logic tx_lamp,
  output logic alarm_indicator_lamp,
  output logic alarm_out,
  output logic controller_state_lamp,
  output logic beeper,
  output logic inhibit_msg,
  output logic float_mode_msg,
  output logic [1:0] screen_sel,
  output logic irq
);
  typedef struct packed {
    logic [15:0] di_s1;
    logic [15:0] di_s2;
    logic rx_s1;
    logic rx_s2;
    logic rx_d;
    logic pan_s1;
    logic pan_s2;
    logic [23:0] rx_cnt;
    logic [23:0] tx_cnt;
    logic [27:0] blink_cnt;
    logic blink;
    logic [2:0] ctrl;
    logic [15:0] invert;
    logic [2:0] soft_auto;
    logic [2:0] mask;
    logic [2:0] ints;
    logic [2:0][1:0] fail;
    logic [2:0][35:0] st_cnt;
    logic float_mode;
    logic float_unsil;
    logic phase_unack;
    logic pq_d;
    logic sil_d;
    logic [2:0] pump_run;
    logic [2:0] na_tag;
    logic rx_lamp;
    logic tx_lamp;
    logic alarm_lamp;
    logic alarm_out;
    logic state_lamp;
    logic beeper;
    logic inhibit_msg;
    logic float_msg;
    logic [1:0] screen;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  always_comb begin
    logic [15:0] di;
    logic [2:0] auto_ok;
    logic [2:0] want;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [2:0] failed;
    logic [31:0] rd;
    logic err;
    logic setup;
    logic wr;
    logic silence;
    logic fail_clr;
    logic float_act;
    logic inhibit;
    logic pq;
    logic alarm;
    int unsigned base;
    nxt_st = st_ff;
    ev = 3'h0;
    clr = 3'h0;
    rd = 32'h0;
    err = 1'b0;
    setup = psel && !penable;
    wr = psel && penable && st_ff.pready && pwrite;
    silence = 1'b0;
    fail_clr = 1'b0;
    auto_ok = 3'h0;
    want = 3'h0;
    failed = 3'h0;
    float_act = 1'b0;
    alarm = 1'b0;
    base = 0;
    // The display and all pump logic see inputs after inversion.
    di = st_ff.di_s2 ^ st_ff.invert;
    inhibit = di[pump_status_pkg::DI_INHIBIT];
    pq = di[pump_status_pkg::DI_POWER_QUALITY];

    // Synchronisers; only the second stage is read by logic.
    nxt_st.di_s1 = di_raw;
    nxt_st.di_s2 = st_ff.di_s1;
    nxt_st.rx_s1 = rx_line;
    nxt_st.rx_s2 = st_ff.rx_s1;
    nxt_st.rx_d = st_ff.rx_s2;
    nxt_st.pan_s1 = panel_present;
    nxt_st.pan_s2 = st_ff.pan_s1;

    // A falling edge on the idle-high line is a start bit, before any
    // address or checksum is known.
    if (st_ff.rx_d && !st_ff.rx_s2) begin
      nxt_st.rx_cnt = 24'(LAMP_STRETCH);
    end else if (st_ff.rx_cnt != 24'h0) begin
      nxt_st.rx_cnt = st_ff.rx_cnt - 24'h1;
    end
    if (tx_active) begin
      nxt_st.tx_cnt = 24'(LAMP_STRETCH);
    end else if (st_ff.tx_cnt != 24'h0) begin
      nxt_st.tx_cnt = st_ff.tx_cnt - 24'h1;
    end
    nxt_st.rx_lamp = (st_ff.rx_d && !st_ff.rx_s2) || st_ff.rx_cnt != 24'h0;
    nxt_st.tx_lamp = tx_active || st_ff.tx_cnt != 24'h0;

    if (st_ff.blink_cnt >= 28'(BLINK_HALF - 1)) begin
      nxt_st.blink_cnt = 28'h0;
      nxt_st.blink = !st_ff.blink;
    end else begin
      nxt_st.blink_cnt = st_ff.blink_cnt + 28'h1;
    end

    // Software register access.
    if (wr) begin
      unique case (paddr)
        pump_status_pkg::CTRL_ADDR: begin
          nxt_st.ctrl = pwdata[2:0];
          silence = pwdata[pump_status_pkg::CTRL_SILENCE];
          fail_clr = pwdata[pump_status_pkg::CTRL_FAIL_CLR];
        end
        pump_status_pkg::INVERT_ADDR: nxt_st.invert = pwdata[15:0];
        pump_status_pkg::SOFT_AUTO_ADDR: nxt_st.soft_auto = pwdata[2:0];
        pump_status_pkg::INT_MASK_ADDR: nxt_st.mask = pwdata[2:0];
        default: ;
      endcase
    end
    if (psel && penable && st_ff.pready && !pwrite &&
        paddr == pump_status_pkg::INT_STATUS_ADDR) begin
      // Clear only what the read returned; a later event stays pending.
      clr = st_ff.prdata[2:0];
    end

    // Alarm silence comes from the panel input edge or from software.
    nxt_st.sil_d = di[pump_status_pkg::DI_SILENCE];
    silence = silence || (di[pump_status_pkg::DI_SILENCE] && !st_ff.sil_d);

    // Pump permissives.
    for (int i = 0; i < 3; i++) begin
      auto_ok[i] = st_ff.soft_auto[i] &&
        (!st_ff.ctrl[pump_status_pkg::CTRL_HARD_MON] || di[3*i+1]);
      failed[i] = st_ff.fail[i] != 2'(pump_status_pkg::FAIL_NONE);
    end

    float_act = st_ff.ctrl[pump_status_pkg::CTRL_PUMP_UP] ?
      di[pump_status_pkg::DI_HIGH_FLOAT] : di[pump_status_pkg::DI_LOW_FLOAT];
    nxt_st.float_mode = st_ff.ctrl[pump_status_pkg::CTRL_FLOAT_EN] &&
      float_act;
    if (nxt_st.float_mode && !st_ff.float_mode) begin
      ev[pump_status_pkg::EV_FLOAT] = 1'b1;
    end
    // Set wins over silence when both land in one cycle.
    nxt_st.float_unsil = ev[pump_status_pkg::EV_FLOAT] ||
      (st_ff.float_unsil && !silence);

    nxt_st.pq_d = pq;
    if (pq && !st_ff.pq_d) begin
      ev[pump_status_pkg::EV_PHASE] = 1'b1;
    end
    nxt_st.phase_unack = ev[pump_status_pkg::EV_PHASE] ||
      (st_ff.phase_unack && pq && !silence);

    // In float mode the lead pump is driven by the float itself.
    want = nxt_st.float_mode ? 3'h1 : stage_call;
    for (int i = 0; i < 3; i++) begin
      nxt_st.pump_run[i] = want[i] && auto_ok[i] && !inhibit &&
        !pq && !failed[i];
      nxt_st.na_tag[i] = !auto_ok[i];
      if (fail_clr) begin
        nxt_st.fail[i] = 2'(pump_status_pkg::FAIL_NONE);
        nxt_st.st_cnt[i] = 36'h0;
      end
      if (st_ff.pump_run[i] && !di[3*i]) begin
        nxt_st.st_cnt[i] = st_ff.st_cnt[i] + 36'h1;
      end else begin
        nxt_st.st_cnt[i] = 36'h0;
      end
      // Overtemperature outranks seal, which outranks a missed start.
      if (!failed[i]) begin
        if (di[3*i+2]) begin
          nxt_st.fail[i] = 2'(pump_status_pkg::FAIL_OVERTEMP);
        end else if (seal_fail[i]) begin
          nxt_st.fail[i] = 2'(pump_status_pkg::FAIL_SEAL);
        end else if (st_ff.st_cnt[i] >= 36'(START_TIMEOUT)) begin
          nxt_st.fail[i] = 2'(pump_status_pkg::FAIL_START);
        end
        if (nxt_st.fail[i] != 2'(pump_status_pkg::FAIL_NONE)) begin
          ev[pump_status_pkg::EV_FAIL] = 1'b1;
        end
      end
    end

    alarm = pq || st_ff.float_unsil || nxt_st.float_mode ||
      (|failed);
    nxt_st.alarm_out = alarm;
    nxt_st.alarm_lamp = alarm;
    nxt_st.inhibit_msg = inhibit;
    nxt_st.float_msg = nxt_st.float_mode;
    nxt_st.beeper = nxt_st.float_unsil;

    // Alarm screens share time with the home screen on the blink phase.
    if (st_ff.blink && nxt_st.phase_unack) begin
      nxt_st.screen = 2'(pump_status_pkg::SCREEN_PHASE);
    end else if (st_ff.blink && nxt_st.float_unsil) begin
      nxt_st.screen = 2'(pump_status_pkg::SCREEN_FLOAT);
    end else begin
      nxt_st.screen = 2'(pump_status_pkg::SCREEN_HOME);
    end

    if (config_corrupt) begin
      nxt_st.state_lamp = st_ff.blink;
    end else begin
      nxt_st.state_lamp = st_ff.pan_s2;
    end

    nxt_st.ints = (st_ff.ints & ~clr) | ev;
    nxt_st.irq = |(nxt_st.ints & st_ff.mask);

    // Read data is prepared in the setup phase; no wait states.
    if (paddr == pump_status_pkg::CTRL_ADDR) begin
      rd = {29'h0, st_ff.ctrl};
    end else if (paddr == pump_status_pkg::INVERT_ADDR) begin
      rd = {16'h0, st_ff.invert};
    end else if (paddr == pump_status_pkg::SOFT_AUTO_ADDR) begin
      rd = {29'h0, st_ff.soft_auto};
    end else if (paddr == pump_status_pkg::STATUS_ADDR) begin
      rd = {13'h0, st_ff.beeper, st_ff.state_lamp, st_ff.alarm_out,
            st_ff.screen, st_ff.float_msg, st_ff.inhibit_msg, st_ff.fail,
            st_ff.na_tag, st_ff.pump_run};
    end else if (paddr == pump_status_pkg::INT_STATUS_ADDR) begin
      rd = {29'h0, st_ff.ints};
    end else if (paddr == pump_status_pkg::INT_MASK_ADDR) begin
      rd = {29'h0, st_ff.mask};
    end else if (paddr >= pump_status_pkg::DISPLAY_ADDR &&
                 paddr <= pump_status_pkg::DISPLAY_LAST_ADDR &&
                 paddr[1:0] == 2'h0) begin
      base = 4 * 32'(paddr - pump_status_pkg::DISPLAY_ADDR) / 4;
      for (int k = 0; k < 4; k++) begin
        // Every input is shown, whether its function is in use or not.
        rd[8*k +: 8] = pump_status_pkg::di_char(base + k,
          di[base + k]);
      end
    end else begin
      err = 1'b1;
    end
    if (setup) begin
      nxt_st.prdata = pwrite ? 32'h0 : rd;
      nxt_st.pslverr = err;
      nxt_st.pready = 1'b1;
    end else begin
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.rx_s1 <= 1'b1;
      st_ff.rx_s2 <= 1'b1;
      st_ff.rx_d <= 1'b1;
      st_ff.ctrl <= pump_status_pkg::CTRL_RESET;
      st_ff.invert <= pump_status_pkg::INVERT_RESET;
      st_ff.soft_auto <= pump_status_pkg::SOFT_AUTO_RESET;
      st_ff.mask <= pump_status_pkg::INT_MASK_RESET;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign pump_run = st_ff.pump_run;
  assign not_in_auto_tag = st_ff.na_tag;
  assign rx_lamp = st_ff.rx_lamp;
  assign tx_lamp = st_ff.tx_lamp;
  assign alarm_indicator_lamp = st_ff.alarm_lamp;
  assign alarm_out = st_ff.alarm_out;
  assign controller_state_lamp = st_ff.state_lamp;
  assign beeper = st_ff.beeper;
  assign inhibit_msg = st_ff.inhibit_msg;
  assign float_mode_msg = st_ff.float_msg;
  assign screen_sel = st_ff.screen;
  assign irq = st_ff.irq;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic [15:0] di_now;
  assign di_now = st_ff.di_s2 ^ st_ff.invert;

  rx_lamp_a: assert property (
    (ce && st_ff.rx_d && !st_ff.rx_s2) |=> rx_lamp)
    else $error("receive lamp missed a start bit");
  tx_lamp_a: assert property (
    (ce && tx_active) |=> tx_lamp)
    else $error("transmit lamp dark while sending");
  alarm_lamp_a: assert property (
    alarm_indicator_lamp == alarm_out)
    else $error("alarm lamp differs from alarm output");
  state_blink_a: assert property (
    (ce && config_corrupt) |=> controller_state_lamp == $past(st_ff.blink))
    else $error("state lamp not blinking on corruption");
  state_panel_a: assert property (
    (ce && !config_corrupt) |=> controller_state_lamp == $past(st_ff.pan_s2))
    else $error("state lamp does not follow panel presence");
  inhibit_stop_a: assert property (
    (ce && di_now[pump_status_pkg::DI_INHIBIT]) |=> pump_run == 3'h0
      && inhibit_msg)
    else $error("pump ran while inhibited");
  soft_auto_a: assert property (
    (ce && !st_ff.soft_auto[0]) |=> !pump_run[0] && not_in_auto_tag[0])
    else $error("pump ran outside auto");
  power_block_a: assert property (
    (ce && di_now[pump_status_pkg::DI_POWER_QUALITY]) |=> pump_run == 3'h0)
    else $error("pump ran during power fault");
  float_beep_a: assert property (
    beeper |-> alarm_out)
    else $error("beeper without alarm");
  stretch_a: assert property (
    (ce && st_ff.rx_d && !st_ff.rx_s2) ##1 ce |=> rx_lamp)
    else $error("receive lamp not stretched");

  rx_seen_c: cover property (rx_lamp ##1 !rx_lamp);
  phase_screen_c: cover property (
    screen_sel == 2'(pump_status_pkg::SCREEN_PHASE));
  float_mode_c: cover property (float_mode_msg && beeper);
endmodule

// >>> pump_field_model.sv
// Far side model: field inputs, operator panel and telemetry master.
module pump_field_model (
  input wire logic clock,
  input wire logic [15:0] di_cmd,
  input wire logic panel_cmd,
  input wire logic send,
  input wire logic [7:0] byte_val,
  output logic [15:0] di_raw,
  output logic panel_present,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] frame_ff = 10'h3ff;
  logic [5:0] left_ff = 6'h00;
  // Bits last four cycles; the line idles high between frames, so only a
  // real start bit can wake the receive lamp.
  always @(posedge clock) begin
    di_raw <= di_cmd;
    panel_present <= panel_cmd;
    rx_line <= (left_ff != 6'h00) ? frame_ff[0] : 1'b1;
    if (send && left_ff == 6'h00) begin
      frame_ff <= {1'b1, byte_val, 1'b0};
      left_ff <= 6'h28;
    end else if (left_ff != 6'h00) begin
      left_ff <= left_ff - 6'h01;
      if (left_ff[1:0] == 2'h1) begin
        frame_ff <= {1'b1, frame_ff[9:1]};
      end
    end
  end
endmodule

// >>> pump_status_indication_logic_tb.sv
// Self-checking testbench for the pump status indication logic.
module pump_status_indication_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STRETCH = 8;
  localparam int unsigned HALF = 16;
  localparam int unsigned START_TO = 20;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] seal_fail = 3'h0;
  logic [2:0] stage_call = 3'h0;
  logic tx_active = 1'b0;
  logic config_corrupt = 1'b0;
  logic [15:0] di_cmd = 16'h0000;
  logic panel_cmd = 1'b0;
  logic send = 1'b0;
  logic [7:0] byte_val = 8'h00;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, rx_line, panel_present, irq, beeper;
  logic rx_lamp, tx_lamp, alarm_indicator_lamp, alarm_out;
  logic controller_state_lamp, inhibit_msg, float_mode_msg;
  logic [2:0] pump_run, not_in_auto_tag;
  logic [1:0] screen_sel;
  logic [15:0] di_raw, di, inv;
  logic [31:0] seed = 32'h0000000b;
  logic [3:0] scr_seen;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int st_hi, st_lo, rx_n, tx_n;
  int al_bad = 0;

  pump_status #(.LAMP_STRETCH(STRETCH), .BLINK_HALF(HALF),
    .START_TIMEOUT(64'(START_TO))) dut_u (
    .clock, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .di_raw, .rx_line, .panel_present,
    .seal_fail, .tx_active, .config_corrupt, .stage_call, .pump_run,
    .not_in_auto_tag, .rx_lamp, .tx_lamp, .alarm_indicator_lamp,
    .alarm_out, .controller_state_lamp, .beeper, .inhibit_msg,
    .float_mode_msg, .screen_sel, .irq);
  pump_field_model field_u (.clock, .di_cmd, .panel_cmd, .send,
    .byte_val, .di_raw, .panel_present, .rx_line);

  initial begin
    forever #2.5 clock = ~clock;
  end

  function automatic logic [15:0] rnd16();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  function automatic logic [31:0] disp(logic [15:0] v, int w);
    logic [31:0] r;
    int i;
    for (int k = 0; k < 4; k++) begin
      i = 4 * w + k;
      r[8*k +: 8] = !v[i] ? 8'h2d : (i < 9 ? 8'h31 + 8'(i) : 8'h38 + 8'(i));
    end
    return r;
  endfunction

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic watch(int n);
    scr_seen = 4'h0;
    st_hi = 0;
    st_lo = 0;
    rx_n = 0;
    tx_n = 0;
    repeat (n) begin
      @(posedge clock);
      scr_seen[screen_sel] = 1'b1;
      st_hi += int'(controller_state_lamp === 1'b1);
      st_lo += int'(controller_state_lamp === 1'b0);
      rx_n += int'(rx_lamp === 1'b1);
      tx_n += int'(tx_lamp === 1'b1);
      al_bad += int'(alarm_indicator_lamp !== alarm_out);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole sequence needs under a thousand cycles; this is ample margin.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    for (int j = 0; j < 6; j++) begin
      if (j != 3) begin
        apb(1'b0, 8'(4 * j), 32'h0);
        chk("reset value", (j == 2) ? 32'h7 : 32'h0, q);
      end
    end
    apb(1'b1, 8'h28, 32'hffffffff);
    chk("unmapped error", 32'h1, 32'(e));
    for (int t = 0; t < 5; t++) begin
      di = (t == 0) ? 16'hffff : rnd16();
      inv = (t == 1) ? 16'hffff : rnd16();
      apb(1'b1, 8'h04, {16'h0000, inv});
      di_cmd <= di;
      cyc(8);
      for (int w = 0; w < 4; w++) begin
        apb(1'b0, 8'h18 + 8'(4 * w), 32'h0);
        chk("display word", disp(di ^ inv, w), q);
      end
    end
    apb(1'b1, 8'h04, 32'h0);
    di_cmd <= 16'h00db;
    stage_call <= 3'h7;
    apb(1'b1, 8'h08, 32'h5);
    // Random inputs above may have latched overtemperature faults.
    apb(1'b1, 8'h00, 32'h10);
    cyc(8);
    chk("run soft selector", 32'h5, 32'(pump_run));
    chk("tag soft selector", 32'h2, 32'(not_in_auto_tag));
    apb(1'b1, 8'h08, 32'h7);
    apb(1'b1, 8'h00, 32'h2);
    di_cmd <= 16'h00d9;
    cyc(8);
    chk("run hard selector", 32'h6, 32'(pump_run));
    chk("tag hard selector", 32'h1, 32'(not_in_auto_tag));
    apb(1'b1, 8'h00, 32'h0);
    ce <= 1'b0;
    di_cmd <= 16'h10db;
    cyc(8);
    chk("run frozen", 32'h6, 32'(pump_run));
    ce <= 1'b1;
    cyc(8);
    chk("run inhibited", 32'h0, 32'(pump_run));
    chk("inhibit message", 32'h1, 32'(inhibit_msg));
    apb(1'b0, 8'h10, 32'h0);
    apb(1'b1, 8'h14, 32'h1);
    di_cmd <= 16'h20db;
    watch(4 * HALF);
    chk("run power fault", 32'h0, 32'(pump_run));
    chk("phase screens", 32'h3, 32'(scr_seen));
    chk("alarm lamp", 32'h1, 32'(alarm_indicator_lamp));
    chk("power irq", 32'h1, 32'(irq));
    apb(1'b0, 8'h10, 32'h0);
    chk("power logged", 32'h1, 32'(q[0]));
    apb(1'b0, 8'h10, 32'h0);
    chk("status cleared", 32'h0, 32'(q[0]));
    apb(1'b1, 8'h00, 32'h8);
    watch(4 * HALF);
    chk("acknowledged screen", 32'h1, 32'(scr_seen));
    apb(1'b1, 8'h00, 32'h10);
    di_cmd <= 16'h00fa;
    seal_fail <= 3'h4;
    cyc(3 * START_TO);
    apb(1'b0, 8'h0c, 32'h0);
    chk("fail codes", 32'h39, 32'(q[11:6]));
    di_cmd <= 16'h00db;
    seal_fail <= 3'h0;
    cyc(8);
    apb(1'b0, 8'h0c, 32'h0);
    chk("fail sticky", 32'h39, 32'(q[11:6]));
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h0c, 32'h0);
    chk("fail cleared", 32'h0, 32'(q[11:6]));
    apb(1'b1, 8'h00, 32'h1);
    di_cmd <= 16'h04db;
    watch(4 * HALF);
    chk("float message", 32'h1, 32'(float_mode_msg));
    chk("float beeper", 32'h1, 32'(beeper));
    chk("float screens", 32'h5, 32'(scr_seen));
    apb(1'b0, 8'h10, 32'h0);
    chk("float event", 32'h1, 32'(q[1]));
    apb(1'b1, 8'h00, 32'h9);
    cyc(4);
    chk("beeper silenced", 32'h0, 32'(beeper));
    byte_val <= 8'(rnd16());
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    cyc(8);
    chk("rx lamp", 32'h1, 32'(rx_lamp));
    watch(60);
    chk("rx stretch", 32'h1, 32'(rx_n >= STRETCH));
    tx_active <= 1'b1;
    @(posedge clock);
    tx_active <= 1'b0;
    watch(30);
    chk("tx stretch", 32'h1, 32'(tx_n >= STRETCH));
    watch(40);
    chk("state lamp off", 32'h0, 32'(st_hi));
    panel_cmd <= 1'b1;
    cyc(8);
    watch(40);
    chk("state lamp on", 32'h0, 32'(st_lo));
    config_corrupt <= 1'b1;
    watch(4 * HALF);
    chk("state lamp blink", 32'h1, 32'(st_hi > 0 && st_lo > 0));
    chk("alarm mirror", 32'h0, 32'(al_bad));
    complete_run();
  end
endmodule
